/* logic/cmo_pkg.sv */
// Shared constants and types for the cache maintenance unit
package cmo_pkg;
    localparam int unsigned ADDR_W        = 32;
    localparam int unsigned WAYS          = 2;
    localparam int unsigned LINES         = 512;
    localparam int unsigned IDX_W         = 9;
    localparam int unsigned LINE_BYTES    = 32;
    localparam int unsigned OFS_W         = 5;
    localparam int unsigned TAG_W         = ADDR_W - IDX_W - OFS_W;
    localparam int unsigned S_STRIDE      = 16384;
    localparam int unsigned IMM_SHIFT     = 5;
    // Source field positions, zero based (documented one based: 15, 14..6, 19)
    localparam int unsigned WAY_BIT       = 14;
    localparam int unsigned IDX_LSB       = 5;
    localparam int unsigned VALID_BIT     = 18;
    localparam int unsigned INV_EXTRA     = 4;
    localparam int unsigned CLEAN_CYCLES  = 5;
    localparam int unsigned DIRTY_CYCLES  = 13;
    localparam logic        RESET_VALID   = 1'b0;
    localparam logic        RESET_DIRTY   = 1'b0;
    localparam logic        RESET_MRU     = 1'b0;

    typedef enum logic [2:0] {
        CMO_NONE,
        CMO_INV_ADDR,
        CMO_FLUSH_ADDR,
        CMO_FLINV_ADDR,
        CMO_WB_TAG,
        CMO_LA_TAG,
        CMO_LV_TAG,
        CMO_TW_TAG
    } cmo_op_t;
endpackage

/* logic/cmo_cycle_timer.sv */
// Down counter that paces the busy period of one operation
`timescale 1ns/1ps
`default_nettype none
module cmo_cycle_timer #(
    parameter int unsigned CNT_W = 5
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    // Control
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] count_i,
    input  wire logic             hold_i,
    // Status
    output logic                  done_o
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (load_i) begin
            next_cnt = count_i;
        end else if (cnt != '0 && !(hold_i && cnt == CNT_W'(1))) begin
            next_cnt = cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign done_o = (cnt == CNT_W'(1)) && !hold_i;
endmodule // cmo_cycle_timer
`default_nettype wire

/* logic/cmo_cache_maint.sv */
// Cache maintenance unit for a two-way data cache tag array
`timescale 1ns/1ps
`default_nettype none
module cmo_cache_maint
    import cmo_pkg::*;
#(
    parameter int unsigned WB_CNT_W = 5
) (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  resetn_i,
    // Instruction issue
    input  wire logic                  op_valid_i,
    input  wire cmo_pkg::cmo_op_t      op_i,
    input  wire logic [31:0]           rs_i,
    input  wire logic                  imm_s_i,
    input  wire logic [3:0]            imm_ofs_i,
    output logic                       stall_o,
    output logic                       done_o,
    output logic [31:0]                result_o,
    // Allocation request from the load/store path
    input  wire logic                  alloc_i,
    input  wire logic [31:0]           alloc_addr_i,
    input  wire logic                  alloc_dirty_i,
    output logic                       alloc_way_o,
    // Write-back port towards memory
    output logic                       wb_req_o,
    output logic [31:0]                wb_addr_o,
    input  wire logic                  wb_ack_i
);
    import cmo_pkg::*;

    typedef enum logic [1:0] {CMO_IDLE, CMO_BUSY, CMO_WB} cmo_state_t;

    logic [TAG_W-1:0] tag_mem   [WAYS][LINES];
    logic             valid_mem [WAYS][LINES];
    logic             dirty_mem [WAYS][LINES];
    logic             mru_mem   [LINES];

    cmo_state_t       state, next_state;
    logic             stall, next_stall;
    logic             done, next_done;
    logic [31:0]      result, next_result;
    logic             wb_req, next_wb_req;
    logic [31:0]      wb_addr, next_wb_addr;
    logic             alloc_way, next_alloc_way;
    logic             way_q, next_way_q;
    logic [IDX_W-1:0] idx_q, next_idx_q;
    logic             inval_q, next_inval_q;

    logic [31:0]      addr;
    logic [IDX_W-1:0] a_idx, t_idx, al_idx;
    logic [TAG_W-1:0] a_tag;
    logic             t_way;
    logic [1:0]       hit_v;
    logic             hit, hit_way;
    logic             t_load, t_hold, t_done;
    logic [WB_CNT_W-1:0] t_count;

    // Address form for address-based operations
    assign addr  = rs_i + (imm_s_i ? 32'(S_STRIDE) : 32'h0000_0000)
                 + {23'h00_0000, imm_ofs_i, 5'h00};
    assign a_idx = addr[OFS_W +: IDX_W];
    assign a_tag = addr[ADDR_W-1 -: TAG_W];
    // Position for tag-based operations
    assign t_way = rs_i[WAY_BIT] ^ imm_s_i;
    assign t_idx = rs_i[IDX_LSB +: IDX_W] + {5'h00, imm_ofs_i};
    assign al_idx = alloc_addr_i[OFS_W +: IDX_W];

    genvar gw;
    generate
        for (gw = 0; gw < WAYS; gw++) begin : g_hit
            assign hit_v[gw] = valid_mem[gw][a_idx]
                             && tag_mem[gw][a_idx] == a_tag;
        end
    endgenerate
    assign hit     = |hit_v;
    assign hit_way = hit_v[1];

    cmo_cycle_timer #(.CNT_W(WB_CNT_W)) u_timer (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .load_i    (t_load),
        .count_i   (t_count),
        .hold_i    (t_hold),
        .done_o    (t_done)
    );

    logic issue;
    assign issue = op_valid_i && state == CMO_IDLE;

    always_comb begin
        next_state     = state;
        next_stall     = stall;
        next_done      = 1'b0;
        next_result    = result;
        next_wb_req    = wb_req;
        next_wb_addr   = wb_addr;
        next_way_q     = way_q;
        next_idx_q     = idx_q;
        next_inval_q   = inval_q;
        next_alloc_way = alloc_way;
        t_load  = 1'b0;
        t_count = '0;
        t_hold  = (state == CMO_WB) && wb_req;
        if (alloc_i) begin
            if (!valid_mem[0][al_idx]) begin
                next_alloc_way = 1'b0;
            end else if (!valid_mem[1][al_idx]) begin
                next_alloc_way = 1'b1;
            end else begin
                next_alloc_way = ~mru_mem[al_idx];
            end
        end
        case (state)
            CMO_IDLE: begin
                if (issue) begin
                    next_way_q   = hit_way;
                    next_idx_q   = a_idx;
                    next_inval_q = (op_i == CMO_FLINV_ADDR);
                    case (op_i)
                        CMO_INV_ADDR: begin
                            next_done = !hit;
                            if (hit) begin
                                t_load = 1'b1;
                                t_count = WB_CNT_W'(INV_EXTRA);
                                next_state = CMO_BUSY;
                                next_stall = 1'b1;
                            end
                        end
                        CMO_FLUSH_ADDR, CMO_FLINV_ADDR: begin
                            next_done = !hit;
                            if (hit) begin
                                next_stall = 1'b1;
                                if (dirty_mem[hit_way][a_idx]) begin
                                    t_load = 1'b1;
                                    t_count = WB_CNT_W'(DIRTY_CYCLES - 1);
                                    next_state = CMO_WB;
                                    next_wb_req = 1'b1;
                                    next_wb_addr = {a_tag, a_idx, 5'h00};
                                end else begin
                                    t_load = 1'b1;
                                    t_count = WB_CNT_W'(CLEAN_CYCLES - 1);
                                    next_state = CMO_BUSY;
                                end
                            end
                        end
                        CMO_WB_TAG: begin
                            next_way_q = t_way;
                            next_idx_q = t_idx;
                            next_inval_q = 1'b0;
                            if (valid_mem[t_way][t_idx]
                                    && dirty_mem[t_way][t_idx]) begin
                                t_load = 1'b1;
                                t_count = WB_CNT_W'(DIRTY_CYCLES - 1);
                                next_state = CMO_WB;
                                next_stall = 1'b1;
                                next_wb_req = 1'b1;
                                next_wb_addr = {tag_mem[t_way][t_idx],
                                                t_idx, 5'h00};
                            end else begin
                                next_done = 1'b1;
                            end
                        end
                        CMO_LA_TAG: begin
                            next_result = {tag_mem[t_way][t_idx],
                                           t_idx, 5'h00};
                            next_done = 1'b1;
                        end
                        CMO_LV_TAG: begin
                            next_result = {31'h0000_0000,
                                           valid_mem[t_way][t_idx]};
                            next_done = 1'b1;
                        end
                        default: begin
                            next_done = 1'b1;
                        end
                    endcase
                end
            end
            CMO_WB: begin
                if (wb_ack_i) begin
                    next_wb_req = 1'b0;
                end
                if (t_done) begin
                    next_state = CMO_IDLE;
                    next_stall = 1'b0;
                    next_done  = 1'b1;
                end
            end
            CMO_BUSY: begin
                if (t_done) begin
                    next_state = CMO_IDLE;
                    next_stall = 1'b0;
                    next_done  = 1'b1;
                end
            end
            default: begin
                next_state = CMO_IDLE;
                next_stall = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state     <= CMO_IDLE;
            stall     <= 1'b0;
            done      <= 1'b0;
            result    <= 32'h0000_0000;
            wb_req    <= 1'b0;
            wb_addr   <= 32'h0000_0000;
            way_q     <= 1'b0;
            idx_q     <= '0;
            inval_q   <= 1'b0;
            alloc_way <= 1'b0;
        end else begin
            state     <= next_state;
            stall     <= next_stall;
            done      <= next_done;
            result    <= next_result;
            wb_req    <= next_wb_req;
            wb_addr   <= next_wb_addr;
            way_q     <= next_way_q;
            idx_q     <= next_idx_q;
            inval_q   <= next_inval_q;
            alloc_way <= next_alloc_way;
        end
    end

    // Tag array updates
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int w = 0; w < WAYS; w++) begin
                for (int l = 0; l < LINES; l++) begin
                    valid_mem[w][l] <= RESET_VALID;
                    dirty_mem[w][l] <= RESET_DIRTY;
                    tag_mem[w][l]   <= '0;
                end
            end
            for (int l = 0; l < LINES; l++) begin
                mru_mem[l] <= RESET_MRU;
            end
        end else begin
            if (alloc_i) begin
                valid_mem[next_alloc_way][al_idx] <= 1'b1;
                dirty_mem[next_alloc_way][al_idx] <= alloc_dirty_i;
                tag_mem[next_alloc_way][al_idx] <=
                    alloc_addr_i[ADDR_W-1 -: TAG_W];
                mru_mem[al_idx] <= next_alloc_way;
            end
            if (issue && op_i == CMO_WB_TAG) begin
                mru_mem[t_idx] <= ~t_way;
            end
            if (issue && op_i == CMO_TW_TAG) begin
                valid_mem[t_way][t_idx] <= rs_i[VALID_BIT];
                tag_mem[t_way][t_idx]   <= rs_i[ADDR_W-1 -: TAG_W];
                dirty_mem[t_way][t_idx] <= 1'b0;
                mru_mem[t_idx] <= ~t_way;
            end
            if (state == CMO_BUSY && t_done && !inval_q
                    && op_i != CMO_INV_ADDR) begin
                dirty_mem[way_q][idx_q] <= 1'b0;
            end
            if (state == CMO_WB && wb_req && wb_ack_i) begin
                dirty_mem[way_q][idx_q] <= 1'b0;
            end
            if (issue && op_i == CMO_INV_ADDR && hit) begin
                valid_mem[hit_way][a_idx] <= 1'b0;
            end
            if (state != CMO_IDLE && t_done && inval_q) begin
                valid_mem[way_q][idx_q] <= 1'b0;
            end
        end
    end

    assign stall_o     = stall;
    assign done_o      = done;
    assign result_o    = result;
    assign wb_req_o    = wb_req;
    assign wb_addr_o   = wb_addr;
    assign alloc_way_o = alloc_way;
endmodule // cmo_cache_maint
`default_nettype wire

/* tb/cmo_mem_model.sv */
// Memory side model that acknowledges write-back requests
`timescale 1ns/1ps
`default_nettype none
module cmo_mem_model (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // Answer delay in cycles
    input  wire logic [4:0]  lat_i,
    // Write-back port
    input  wire logic        wb_req_i,
    input  wire logic [31:0] wb_addr_i,
    output logic             wb_ack_o,
    // Record of accepted write-backs
    output logic [7:0]       wb_cnt_o,
    output logic [31:0]      wb_last_o
);
    logic [4:0] wait_cnt;

    // Acknowledge after lat_i waiting cycles, one pulse per request
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o  <= 1'b0;
            wb_cnt_o  <= 8'h00;
            wb_last_o <= 32'h0000_0000;
            wait_cnt  <= 5'h00;
        end else if (wb_req_i && !wb_ack_o && wait_cnt >= lat_i) begin
            wb_ack_o  <= 1'b1;
            wb_cnt_o  <= wb_cnt_o + 8'h01;
            wb_last_o <= wb_addr_i;
            wait_cnt  <= 5'h00;
        end else begin
            wb_ack_o  <= 1'b0;
            if (wb_req_i && !wb_ack_o) begin
                wait_cnt <= wait_cnt + 5'h01;
            end
        end
    end
endmodule // cmo_mem_model
`default_nettype wire

/* tb/cmo_cache_maint_assertions.sv */
// Port checker for the cache maintenance unit
`timescale 1ns/1ps
`default_nettype none
module cmo_cache_maint_chk
    import cmo_pkg::*;
#(
    parameter int unsigned WB_CNT_W = 5
) (
    input wire logic             clk_sys_i,
    input wire logic             resetn_i,
    input wire logic             op_valid_i,
    input wire cmo_pkg::cmo_op_t op_i,
    input wire logic [31:0]      rs_i,
    input wire logic             imm_s_i,
    input wire logic [3:0]       imm_ofs_i,
    input wire logic             stall_o,
    input wire logic             done_o,
    input wire logic [31:0]      result_o,
    input wire logic             alloc_i,
    input wire logic [31:0]      alloc_addr_i,
    input wire logic             alloc_dirty_i,
    input wire logic             alloc_way_o,
    input wire logic             wb_req_o,
    input wire logic [31:0]      wb_addr_o,
    input wire logic             wb_ack_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic take;
    assign take = op_valid_i && !stall_o;

    stall_done_a: assert property ($fell(stall_o) |-> done_o)
        else $error("stall released without done");
    wb_stall_a: assert property (wb_req_o |-> stall_o)
        else $error("write-back pending without stall");
    wb_hold_a: assert property (wb_req_o && !wb_ack_i |=>
        wb_req_o && $stable(wb_addr_o))
        else $error("write-back request dropped before ack");
    tagq_fast_a: assert property (take && op_i inside {CMO_LA_TAG,
        CMO_LV_TAG, CMO_TW_TAG} |=> done_o && !stall_o && !wb_req_o)
        else $error("tag query not single cycle");
    lv_bit_a: assert property (take && op_i == CMO_LV_TAG |=>
        result_o[31:1] == 31'h0000_0000)
        else $error("validity result has upper bits set");
    clean_time_a: assert property ($rose(stall_o) && !wb_req_o |->
        !done_o [*4] ##1 done_o)
        else $error("clean hit length wrong");
    dirty_time_a: assert property ($rose(stall_o) && wb_req_o &&
        $past(op_i) != CMO_WB_TAG |-> !done_o [*8] ##1 !done_o [*4])
        else $error("dirty flush too short");
    wb_cause_a: assert property ($rose(wb_req_o) |->
        $past(op_valid_i) && $past(op_i) inside {CMO_FLUSH_ADDR,
        CMO_FLINV_ADDR, CMO_WB_TAG})
        else $error("write-back from wrong operation");
    wb_finish_a: assert property (wb_ack_i |-> ##[1:16] done_o)
        else $error("no completion after write-back");
    done_cause_a: assert property (done_o |->
        $past(op_valid_i) || $past(stall_o))
        else $error("done without operation");

    cover property (take && op_i == CMO_INV_ADDR ##1 stall_o);
    cover property ($rose(wb_req_o));
    cover property (take && op_i == CMO_LV_TAG ##1 result_o[0]);
endmodule // cmo_cache_maint_chk

bind cmo_cache_maint cmo_cache_maint_chk #(.WB_CNT_W(WB_CNT_W)) u_chk (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .rs_i(rs_i), .imm_s_i(imm_s_i), .imm_ofs_i(imm_ofs_i),
    .stall_o(stall_o), .done_o(done_o), .result_o(result_o),
    .alloc_i(alloc_i), .alloc_addr_i(alloc_addr_i),
    .alloc_dirty_i(alloc_dirty_i), .alloc_way_o(alloc_way_o),
    .wb_req_o(wb_req_o), .wb_addr_o(wb_addr_o), .wb_ack_i(wb_ack_i));
`default_nettype wire

/* tb/cmo_cache_maint_tb.sv */
// Self-checking bench for the cache maintenance unit
`timescale 1ns/1ps
`default_nettype none
module cmo_cache_maint_tb
    import cmo_pkg::*;
;
    localparam logic [31:0] A0 = 32'h0001_2340;
    localparam logic [31:0] A1 = 32'h0002_2340;
    localparam logic [31:0] A2 = 32'h0003_2340;
    localparam logic [31:0] VM = 32'h0000_0001 << VALID_BIT;
    localparam logic [8:0]  IX = 9'h11a;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, op_valid_i = 1'b0;
    logic imm_s_i = 1'b0, alloc_i = 1'b0, alloc_dirty_i = 1'b0;
    logic stall_o, done_o, alloc_way_o, wb_req_o, wb_ack_i;
    logic [31:0] rs_i = '0, alloc_addr_i = '0, result_o, wb_addr_o, wb_last;
    logic [3:0]  imm_ofs_i = 4'h0;
    logic [4:0]  mem_lat = 5'h00;
    logic [7:0]  wb_cnt, exp_wb = 8'h00;
    cmo_op_t     op_i = CMO_NONE;
    int          fail_count = 0, checks = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    cmo_cache_maint dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .op_valid_i(op_valid_i), .op_i(op_i), .rs_i(rs_i),
        .imm_s_i(imm_s_i), .imm_ofs_i(imm_ofs_i), .stall_o(stall_o),
        .done_o(done_o), .result_o(result_o), .alloc_i(alloc_i),
        .alloc_addr_i(alloc_addr_i), .alloc_dirty_i(alloc_dirty_i),
        .alloc_way_o(alloc_way_o), .wb_req_o(wb_req_o),
        .wb_addr_o(wb_addr_o), .wb_ack_i(wb_ack_i));
    cmo_mem_model mem (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .lat_i(mem_lat), .wb_req_i(wb_req_o), .wb_addr_i(wb_addr_o),
        .wb_ack_o(wb_ack_i), .wb_cnt_o(wb_cnt), .wb_last_o(wb_last));

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [31:0] tp(input logic w, input logic [8:0] x);
        return (32'(w) << WAY_BIT) | (32'(x) << IDX_LSB);
    endfunction

    task automatic issue(input cmo_op_t op, input logic [31:0] rs,
                         input logic s, input logic [3:0] o, output int n);
        op_i = op;
        rs_i = rs;
        imm_s_i = s;
        imm_ofs_i = o;
        op_valid_i = 1'b1;
        @(negedge clk_sys_i);
        op_valid_i = 1'b0;
        n = 1;
        while (done_o !== 1'b1 && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        @(negedge clk_sys_i);
    endtask

    task automatic alloc(input logic [31:0] a, input logic d, w);
        alloc_addr_i = a;
        alloc_dirty_i = d;
        alloc_i = 1'b1;
        @(negedge clk_sys_i);
        alloc_i = 1'b0;
        chk("alloc way", 32'(w), 32'(alloc_way_o));
        @(negedge clk_sys_i);
    endtask

    task automatic lv(input logic w, input logic [8:0] x, input logic e);
        int n;
        issue(CMO_LV_TAG, tp(w, x), 1'b0, 4'h0, n);
        chk("valid flag", {31'h0000_0000, e}, result_o);
    endtask

    task automatic wbchk(input logic [31:0] a);
        exp_wb++;
        chk("write-back count", 32'(exp_wb), 32'(wb_cnt));
        chk("write-back address", a, wb_last);
    endtask

    task automatic t_alloc();
        int n;
        alloc(A0, 1'b0, 1'b0);
        alloc(A1, 1'b1, 1'b1);
        issue(CMO_LA_TAG, tp(1'b0, IX), 1'b0, 4'h0, n);
        chk("line address", A0, result_o);
        issue(CMO_LA_TAG, tp(1'b0, IX - 9'h002), 1'b1, 4'h2, n);
        chk("line address imm", A1, result_o);
        chk("query cycles", 32'h0000_0001, n);
        lv(1'b0, IX + 9'h001, 1'b0);
        $display("test alloc done");
    endtask

    task automatic t_flush();
        int n;
        issue(CMO_FLUSH_ADDR, A2, 1'b0, 4'h0, n);
        chk("miss cycles", 32'h0000_0001, n);
        issue(CMO_FLUSH_ADDR, A0 - S_STRIDE - (32'h0000_0003 << IMM_SHIFT),
              1'b1, 4'h3, n);
        chk("clean cycles", CLEAN_CYCLES, n);
        mem_lat = 5'h0c;
        issue(CMO_FLUSH_ADDR, A1, 1'b0, 4'h0, n);
        chk("dirty long", 32'h0000_0001, 32'(n >= DIRTY_CYCLES));
        wbchk(A1);
        lv(1'b1, IX, 1'b1);
        issue(CMO_FLUSH_ADDR, A1, 1'b0, 4'h0, n);
        chk("dirty cleared", CLEAN_CYCLES, n);
        $display("test flush done");
    endtask

    task automatic t_wbtag();
        int n;
        issue(CMO_WB_TAG, tp(1'b1, IX), 1'b0, 4'h0, n);
        chk("clean no write", 32'(exp_wb), 32'(wb_cnt));
        alloc(A2, 1'b1, 1'b1);
        mem_lat = 5'h00;
        issue(CMO_WB_TAG, tp(1'b1, IX), 1'b0, 4'h0, n);
        wbchk(A2);
        lv(1'b1, IX, 1'b1);
        $display("test write-back done");
    endtask

    task automatic t_flinv();
        int n;
        issue(CMO_FLINV_ADDR, A0, 1'b0, 4'h0, n);
        chk("flinv clean cycles", CLEAN_CYCLES, n);
        lv(1'b0, IX, 1'b0);
        alloc(A0, 1'b1, 1'b0);
        mem_lat = 5'h03;
        issue(CMO_FLINV_ADDR, A0, 1'b0, 4'h0, n);
        chk("flinv long", 32'h0000_0001, 32'(n >= DIRTY_CYCLES));
        wbchk(A0);
        lv(1'b0, IX, 1'b0);
        $display("test flush-invalidate done");
    endtask

    task automatic t_inv();
        int n;
        issue(CMO_INV_ADDR, A2 - (32'h0000_0005 << IMM_SHIFT), 1'b0, 4'h5, n);
        chk("invalidate cycles", 1 + INV_EXTRA, n);
        lv(1'b1, IX, 1'b0);
        issue(CMO_INV_ADDR, A2, 1'b0, 4'h0, n);
        chk("invalidate miss", 32'h0000_0001, n);
        $display("test invalidate done");
    endtask

    task automatic t_tagw();
        int n;
        issue(CMO_TW_TAG, tp(1'b1, IX) | VM, 1'b0, 4'h0, n);
        lv(1'b1, IX, 1'b1);
        issue(CMO_TW_TAG, tp(1'b0, IX) | VM, 1'b0, 4'h0, n);
        alloc(A1, 1'b1, 1'b0);
        issue(CMO_TW_TAG, tp(1'b0, IX) | VM, 1'b0, 4'h0, n);
        issue(CMO_WB_TAG, tp(1'b0, IX), 1'b0, 4'h0, n);
        chk("tag write clean", 32'(exp_wb), 32'(wb_cnt));
        issue(CMO_TW_TAG, tp(1'b0, IX), 1'b0, 4'h0, n);
        lv(1'b0, IX, 1'b0);
        $display("test tag write done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        t_alloc();
        t_flush();
        t_wbtag();
        t_flinv();
        t_inv();
        t_tagw();
        tally_and_finish();
    end
endmodule // cmo_cache_maint_tb
`default_nettype wire
